/* rtl/bmd_channel.sv */
// Purpose: Bus master DMA engine for one disk channel with APB registers.
// Assumes: Memory port answers each request with one ack cycle; drive pins are asynchronous.
// Notes:   One 32-bit word moves per drive request; no write buffering is kept.
//
// Function
// (RULE1) Status bit 7 is read-only zero: both channels may run together.
// (RULE2) Status bit 6 stores software's drive 1 DMA capable flag.
// (RULE3) Status bit 5 stores software's drive 0 DMA capable flag.
// (RULE4) Software writes zeros to reserved status bits 4:3.
// (RULE5) Status bit 2 sets on drive interrupt rising edge; write one clears.
// (RULE6) Interrupt flag shows only after all drive data reached memory.
// (RULE7) Status bit 1 sets on memory transfer failure; write one clears.
// (RULE8) Activity flag sets when start bit is written; resets to zero.
// (RULE9) Activity clears after the last transfer of an end-of-table region.
// (RULE10) Activity clears at once when software clears the start bit.
// (RULE11) Activity zero means all prior drive data is in memory, unless aborted.
// (RULE12) Table pointer holds base bits 31:2; bits 1:0 read zero; resets zero.
// (RULE13) Software keeps the table aligned and inside one 64K region.
// (RULE14) Each descriptor is 8 bytes: buffer address then byte count.
// (RULE15) Descriptor fetch address advances by 8 each time.
// (RULE16) Software loads pointer, direction and clears flags before starting.
// (RULE17) Software commands the drive before setting the start bit.
// (RULE18) Software starts by writing one to the start bit.
// (RULE19) Data moves only in answer to drive DMA requests.
// (RULE20) Software clears start, reads status, then drive status on interrupt.
// (RULE21) Mastering begins on start bit rising; data moves only while set.
// (RULE22) Command bit 3 selects memory reads (0) or memory writes (1).
// (RULE23) Clearing start discards all transfer state; no resume.
// (RULE24) A memory error sets error, stops all work and clears activity.
// (RULE25) Next descriptor is fetched after count runs out, unless end-of-table.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module bmd_channel (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output var  logic [31:0]              prdata,
  output var  logic                     pready,
  output var  logic                     pslverr,
  output var  bmd_pkg::bmd_mem_cmd_type mem_cmd,
  input  wire bmd_pkg::bmd_mem_rsp_type mem_rsp,
  input  wire logic                     secondary_drive_interrupt,
  input  wire logic                     drive_dmarq,
  input  wire logic [31:0]              drive_rdata,
  output var  logic                     drive_dmack,
  output var  logic [31:0]              drive_wdata
);
  import bmd_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_sync;
  logic       intr_s;
  logic       dmarq_s;

  bmd_sync #(.W(2)) u_sync (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .async_in ({secondary_drive_interrupt, drive_dmarq}),
    .sync_out (pin_sync)
  );
  assign intr_s  = pin_sync[1];
  assign dmarq_s = pin_sync[0];

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic          start_r;
  logic          dir_r;
  logic          drv0_dma_r;
  logic          drv1_dma_r;
  logic          intr_r;
  logic          intr_pend_r;
  logic          intr_prev_r;
  logic          err_r;
  logic          active_r;
  logic [29:0]   table_r;
  bmd_state_type state_r;
  logic [31:0]   desc_addr_r;
  logic [31:0]   buf_addr_r;
  logic [16:0]   count_r;
  logic          final_r;

  logic apb_access;
  logic apb_wr;
  logic wr_cmd;
  logic wr_status;
  logic wr_table;
  logic addr_ok;
  logic start_rise;
  logic start_fall;
  logic mem_done;
  logic mem_fail;
  logic last_word;

  assign apb_access = psel & penable & ~pready;
  assign apb_wr     = psel & penable & pready & pwrite;
  assign wr_cmd     = apb_wr & (paddr == BMD_ADDR_COMMAND);
  assign wr_status  = apb_wr & (paddr == BMD_ADDR_STATUS);
  assign wr_table   = apb_wr & (paddr == BMD_ADDR_TABLE);
  assign addr_ok    = (paddr == BMD_ADDR_COMMAND) | (paddr == BMD_ADDR_STATUS) |
                      (paddr == BMD_ADDR_TABLE);
  assign start_rise = wr_cmd & pwdata[BMD_CMD_START] & ~start_r; // RULE21
  assign start_fall = wr_cmd & ~pwdata[BMD_CMD_START] & start_r;
  assign mem_done   = mem_cmd.req & mem_rsp.ack & ~mem_rsp.err;
  assign mem_fail   = mem_cmd.req & mem_rsp.ack & mem_rsp.err;
  assign last_word  = (count_r <= BMD_COUNT_STEP);

  // ----------------------------------------------------------------
  // Command register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      start_r <= BMD_CMD_RESET[BMD_CMD_START];
      dir_r   <= BMD_CMD_RESET[BMD_CMD_DIR];
    end else if (ce && wr_cmd) begin
      start_r <= pwdata[BMD_CMD_START];
      dir_r   <= pwdata[BMD_CMD_DIR]; // RULE22
    end
  end

  // ----------------------------------------------------------------
  // Descriptor table pointer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      table_r <= BMD_TABLE_RESET; // RULE12
    end else if (ce && wr_table) begin
      table_r <= pwdata[31:2]; // RULE12
    end
  end

  // ----------------------------------------------------------------
  // Drive capability flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      drv0_dma_r <= 1'b0;
      drv1_dma_r <= 1'b0;
    end else if (ce && wr_status) begin
      drv1_dma_r <= pwdata[BMD_ST_DRV1_DMA]; // RULE2
      drv0_dma_r <= pwdata[BMD_ST_DRV0_DMA]; // RULE3
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flag
  // ----------------------------------------------------------------
  // An edge seen while a memory write is still open waits in intr_pend_r, so
  // software never sees the flag before the drive's last word is in memory.
  always_ff @(posedge clk) begin
    if (rst) begin
      intr_prev_r <= 1'b0;
      intr_pend_r <= 1'b0;
      intr_r      <= 1'b0;
    end else if (ce) begin
      intr_prev_r <= intr_s;
      if (intr_s && !intr_prev_r && mem_cmd.req && mem_cmd.we) begin
        intr_pend_r <= 1'b1; // RULE6
      end else if (intr_pend_r && !(mem_cmd.req && mem_cmd.we)) begin
        intr_pend_r <= 1'b0;
      end
      if ((intr_s && !intr_prev_r && !(mem_cmd.req && mem_cmd.we)) ||
          (intr_pend_r && !(mem_cmd.req && mem_cmd.we))) begin
        intr_r <= 1'b1; // RULE5 RULE6
      end else if (wr_status && pwdata[BMD_ST_INTR]) begin
        intr_r <= 1'b0; // RULE5
      end
    end
  end

  // ----------------------------------------------------------------
  // Error flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      err_r <= 1'b0;
    end else if (ce) begin
      if (mem_fail) begin
        err_r <= 1'b1; // RULE7 RULE24
      end else if (wr_status && pwdata[BMD_ST_ERROR]) begin
        err_r <= 1'b0; // RULE7
      end
    end
  end

  // ----------------------------------------------------------------
  // Activity flag
  // ----------------------------------------------------------------
  // It falls only after the memory ack of the last word, so a zero means
  // the data has landed unless the command was aborted.
  always_ff @(posedge clk) begin
    if (rst) begin
      active_r <= 1'b0; // RULE8
    end else if (ce) begin
      if (start_rise) begin
        active_r <= 1'b1; // RULE8
      end else if (start_fall || mem_fail) begin
        active_r <= 1'b0; // RULE10 RULE24
      end else if (state_r == BMD_MEMACC && mem_done && !mem_cmd.we && last_word && final_r) begin
        active_r <= active_r; // A read still waits for the drive to take the word.
      end else if (((state_r == BMD_MEMACC && mem_done && mem_cmd.we) ||
                    state_r == BMD_DRVACK) && last_word && final_r) begin
        active_r <= 1'b0; // RULE9 RULE11
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r     <= BMD_IDLE;
      desc_addr_r <= 32'h0000_0000;
      buf_addr_r  <= 32'h0000_0000;
      count_r     <= 17'h0_0000;
      final_r     <= 1'b0;
      mem_cmd     <= '0;
      drive_dmack <= 1'b0;
      drive_wdata <= 32'h0000_0000;
    end else if (ce) begin
      drive_dmack <= 1'b0;
      if (start_fall || mem_fail) begin
        state_r <= BMD_IDLE; // RULE23 RULE24
        mem_cmd <= '0;
        final_r <= 1'b0;
      end else begin
        case (state_r)
          BMD_IDLE: begin
            if (start_rise) begin
              desc_addr_r <= {table_r, 2'b00};
              mem_cmd     <= '{req: 1'b1, we: 1'b0, addr: {table_r, 2'b00}, wdata: 32'h0};
              state_r     <= BMD_FETCH0; // RULE21
            end
          end
          BMD_FETCH0: begin
            if (mem_done) begin
              buf_addr_r  <= mem_rsp.rdata; // RULE14
              mem_cmd     <= '{req: 1'b1, we: 1'b0, addr: desc_addr_r + BMD_WORD_STEP,
                               wdata: 32'h0};
              state_r     <= BMD_FETCH1;
            end
          end
          BMD_FETCH1: begin
            if (mem_done) begin
              count_r <= (mem_rsp.rdata[15:0] == 16'h0000) ? BMD_COUNT_64K
                         : {1'b0, mem_rsp.rdata[15:0]}; // RULE14
              final_r     <= mem_rsp.rdata[BMD_DESC_END];
              desc_addr_r <= desc_addr_r + BMD_DESC_STRIDE; // RULE15
              mem_cmd     <= '0;
              state_r     <= BMD_WAITRQ;
            end
          end
          BMD_WAITRQ: begin
            if (dmarq_s && start_r) begin
              mem_cmd <= '{req: 1'b1, we: dir_r, addr: buf_addr_r,
                           wdata: drive_rdata}; // RULE19 RULE21 RULE22
              state_r <= BMD_MEMACC;
            end
          end
          BMD_MEMACC: begin
            if (mem_done) begin
              mem_cmd <= '0;
              if (mem_cmd.we) begin
                state_r <= BMD_RQLOW;
              end else begin
                drive_wdata <= mem_rsp.rdata;
                drive_dmack <= 1'b1;
                state_r     <= BMD_DRVACK;
              end
              if (mem_cmd.we) begin
                drive_dmack <= 1'b1;
              end
            end
          end
          BMD_DRVACK: begin
            state_r <= BMD_RQLOW;
          end
          BMD_RQLOW: begin
            if (!dmarq_s) begin
              buf_addr_r <= buf_addr_r + BMD_WORD_STEP;
              count_r    <= last_word ? 17'h0_0000 : count_r - BMD_COUNT_STEP;
              if (!last_word) begin
                state_r <= BMD_WAITRQ;
              end else if (final_r) begin
                state_r <= BMD_IDLE;
              end else begin
                mem_cmd <= '{req: 1'b1, we: 1'b0, addr: desc_addr_r,
                             wdata: 32'h0}; // RULE25
                state_r <= BMD_FETCH0;
              end
            end
          end
          default: begin
            state_r <= BMD_IDLE;
            mem_cmd <= '0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // One wait state: pready rises in the second access cycle, from a flop.
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= apb_access;
      pslverr <= apb_access & ~addr_ok;
      prdata  <= 32'h0000_0000;
      if (apb_access && !pwrite) begin
        case (paddr)
          BMD_ADDR_COMMAND: prdata <= {28'h0, dir_r, 2'b00, start_r};
          BMD_ADDR_STATUS:  prdata <= {24'h0, BMD_SIMPLEX_VAL, drv1_dma_r, drv0_dma_r,
                                       2'b00, intr_r, err_r, active_r}; // RULE1
          BMD_ADDR_TABLE:   prdata <= {table_r, 2'b00}; // RULE12
          default:          prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/bmd_pkg.sv */
// Purpose: Shared constants and types of the bus master disk channel DMA block.
// Assumes: APB register access, 32-bit data, one aligned word per register.
// Notes:   Register indices are kept as printed; byte address is four times the index.
package bmd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] BMD_IDX_COMMAND = 8'h08;
  localparam logic [7:0] BMD_IDX_STATUS  = 8'h0A;
  localparam logic [7:0] BMD_IDX_TABLE   = 8'h0C;
  localparam logic [7:0] BMD_ADDR_COMMAND = {BMD_IDX_COMMAND[5:0], 2'b00};
  localparam logic [7:0] BMD_ADDR_STATUS  = {BMD_IDX_STATUS[5:0], 2'b00};
  localparam logic [7:0] BMD_ADDR_TABLE   = {BMD_IDX_TABLE[5:0], 2'b00};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BMD_CMD_START   = 0;
  localparam int BMD_CMD_DIR     = 3;
  localparam int BMD_ST_ACTIVE   = 0;
  localparam int BMD_ST_ERROR    = 1;
  localparam int BMD_ST_INTR     = 2;
  localparam int BMD_ST_DRV0_DMA = 5;
  localparam int BMD_ST_DRV1_DMA = 6;
  localparam int BMD_ST_SIMPLEX  = 7;
  localparam int BMD_DESC_END    = 31;

  // ----------------------------------------------------------------
  // Reset values and fixed amounts
  // ----------------------------------------------------------------
  localparam logic [7:0]  BMD_CMD_RESET    = 8'h00;
  localparam logic [29:0] BMD_TABLE_RESET  = 30'h0000_0000;
  localparam logic        BMD_SIMPLEX_VAL  = 1'b0;
  localparam logic [31:0] BMD_DESC_STRIDE  = 32'h0000_0008;
  localparam logic [31:0] BMD_WORD_STEP    = 32'h0000_0004;
  localparam logic [16:0] BMD_COUNT_STEP   = 17'h0_0004;
  localparam logic [16:0] BMD_COUNT_64K    = 17'h1_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    BMD_IDLE   = 7'b000_0001,
    BMD_FETCH0 = 7'b000_0010,
    BMD_FETCH1 = 7'b000_0100,
    BMD_WAITRQ = 7'b000_1000,
    BMD_MEMACC = 7'b001_0000,
    BMD_DRVACK = 7'b010_0000,
    BMD_RQLOW  = 7'b100_0000
  } bmd_state_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bmd_mem_cmd_type;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } bmd_mem_rsp_type;

endpackage

/* rtl/bmd_sync.sv */
// Purpose: Two-flop synchroniser for levels arriving from pins.
// Assumes: Inputs are asynchronous to clk.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ps
`default_nettype none
module bmd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* test/bmd_channel_checker.sv */
// Purpose: Port assertions for the disk channel DMA block.
// Assumes: The APB master holds paddr and pwrite through the answer cycle.
// Notes:   Start and direction are shadowed from taken command writes.
`timescale 1ns/1ps
`default_nettype none
module bmd_channel_checker (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire bmd_pkg::bmd_mem_cmd_type mem_cmd,
  input wire bmd_pkg::bmd_mem_rsp_type mem_rsp,
  input wire logic                     drive_dmarq,
  input wire logic [31:0]              drive_rdata,
  input wire logic                     drive_dmack,
  input wire logic [31:0]              drive_wdata
);
  import bmd_pkg::*;
  logic start_sh;
  logic dir_sh;
  // --------
  // Command shadow
  // --------
  always_ff @(posedge clk) begin
    if (rst) begin
      start_sh <= 1'b0;
      dir_sh   <= 1'b0;
    end else if (psel && penable && pwrite && pready && paddr == BMD_ADDR_COMMAND) begin
      start_sh <= pwdata[BMD_CMD_START];
      dir_sh   <= pwdata[BMD_CMD_DIR];
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // --------
  // Assertions
  // --------
  chk_simplex_zero: assert property (
    pready && !pwrite && paddr == BMD_ADDR_STATUS |-> prdata[BMD_ST_SIMPLEX] == BMD_SIMPLEX_VAL)
    else $error("simplex bit reads one");
  chk_table_low: assert property (
    pready && !pwrite && paddr == BMD_ADDR_TABLE |-> prdata[1:0] == 2'b00)
    else $error("table pointer low bits not zero");
  chk_idle_quiet: assert property (
    !start_sh && !$past(start_sh) |-> !drive_dmack && !mem_cmd.req)
    else $error("transfer activity while start is clear");
  chk_write_dir: assert property (
    mem_cmd.req && mem_cmd.we |-> dir_sh)
    else $error("memory write while direction selects reads");
  chk_dmack_cause: assert property (
    drive_dmack |-> drive_dmarq && $past(drive_dmarq, 2))
    else $error("word handed without a drive request");
  chk_err_stop: assert property (
    mem_cmd.req && mem_rsp.ack && mem_rsp.err |=> (!mem_cmd.req && !drive_dmack) [*4])
    else $error("engine kept working after a memory error");
  chk_wr_data: assert property (
    mem_cmd.req && mem_cmd.we |-> mem_cmd.wdata == drive_rdata)
    else $error("memory write data differs from drive data");
  chk_rd_data: assert property (
    drive_dmack && !dir_sh |-> drive_wdata == $past(mem_rsp.rdata))
    else $error("drive word differs from memory read data");
endmodule
`default_nettype wire

/* test/bmd_channel_tb.sv */
// Purpose: Self-checking bench for the disk channel DMA block.
// Assumes: The far side model answers memory and drive requests.
// Notes:   Drivers queue expectations; one monitor compares them.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module bmd_channel_tb;
  import bmd_pkg::*;
  logic            clk, rst, ce, psel, penable, pwrite, pready, pslverr;
  logic            intr, drive_dmarq, drive_dmack, slow, drv_load;
  logic [7:0]      paddr, drv_words;
  logic [31:0]     pwdata, prdata, drive_rdata, drive_wdata, err_addr, drv_base, rnd, q, e_dw;
  logic [32:0]     e_rd;
  logic [63:0]     e_mw;
  logic            dir_b;
  bmd_mem_cmd_type mem_cmd;
  bmd_mem_rsp_type mem_rsp;
  logic [32:0]     exp_rd[$];
  logic [63:0]     exp_mw[$];
  logic [31:0]     exp_dw[$];
  int              failures;
  int              samples_checked;
  bmd_channel DUT (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_cmd(mem_cmd), .mem_rsp(mem_rsp), .secondary_drive_interrupt(intr),
    .drive_dmarq(drive_dmarq), .drive_rdata(drive_rdata), .drive_dmack(drive_dmack),
    .drive_wdata(drive_wdata));
  bmd_far u_far (.clk(clk), .rst(rst), .slow(slow), .err_addr(err_addr), .mem_cmd(mem_cmd),
    .mem_rsp(mem_rsp), .drv_load(drv_load), .drv_words(drv_words), .drv_base(drv_base),
    .drive_dmack(drive_dmack), .drive_dmarq(drive_dmarq), .drive_rdata(drive_rdata));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back({1'b0, e});
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic load(input logic [7:0] n);
    drv_words <= n;
    drv_load  <= 1'b1;
    @(posedge clk);
    drv_load  <= 1'b0;
  endtask
  task automatic desc(input int i, input logic [31:0] b, input logic [31:0] c);
    u_far.mem[i]     = b;
    u_far.mem[i + 1] = c;
  endtask
  task automatic run(input logic [31:0] tbl, input logic d, input logic [7:0] n);
    dir_b = d;
    apb(BMD_ADDR_TABLE, 1'b1, tbl);
    apb(BMD_ADDR_STATUS, 1'b1, 32'h66);
    apb(BMD_ADDR_COMMAND, 1'b1, {28'h0, d, 3'b000});
    load(n);
    apb(BMD_ADDR_COMMAND, 1'b1, {28'h0, d, 3'b001});
  endtask
  task automatic wait_idle();
    q = 32'h1;
    while (q[0] !== 1'b0) apb(BMD_ADDR_STATUS, 1'b0, 32'h0);
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // --------
  // Result monitor
  // --------
  always @(posedge clk) begin
    if (pready === 1'b1 && pwrite === 1'b0 && exp_rd.size() > 0) begin
      e_rd = exp_rd.pop_front();
      `CHK({pslverr, prdata}, e_rd)
    end
    if (mem_rsp.ack === 1'b1 && mem_cmd.req === 1'b1 && mem_cmd.we === 1'b1 && exp_mw.size() > 0) begin
      e_mw = exp_mw.pop_front();
      `CHK({mem_cmd.addr, mem_cmd.wdata}, e_mw)
    end
    if (drive_dmack === 1'b1 && !dir_b && exp_dw.size() > 0) begin
      e_dw = exp_dw.pop_front();
      `CHK(drive_wdata, e_dw)
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run();
  end
  initial begin
    {rst, ce} = 2'b11;
    {psel, penable, pwrite, intr, slow, drv_load, dir_b} = '0;
    {paddr, drv_words, pwdata, drv_base} = '0;
    err_addr = 32'hFFFF_FFFC;
    rnd = 32'h7139;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(BMD_ADDR_COMMAND, 32'h0);
    rd(BMD_ADDR_STATUS, 32'h0);
    rd(BMD_ADDR_TABLE, 32'h0);
    exp_rd.push_back({1'b1, 32'h0});
    apb(8'h3C, 1'b0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(BMD_ADDR_STATUS, 1'b1, 32'h87 | (i << 5));
      rd(BMD_ADDR_STATUS, 32'(i << 5));
    end
    rnd = xs(rnd);
    apb(BMD_ADDR_TABLE, 1'b1, rnd);
    rd(BMD_ADDR_TABLE, rnd & 32'hFFFF_FFFC);
    $display("test registers done");
    rnd = xs(rnd);
    slow <= 1'b1;
    drv_base <= rnd;
    desc(32'h40, 32'h200, 32'h0000_0008);
    desc(32'h42, 32'h300, 32'h8000_0004);
    for (int k = 0; k < 3; k++)
      exp_mw.push_back({(k < 2) ? 32'(32'h200 + 4 * k) : 32'h300, rnd ^ 32'(k)});
    run(32'h100, 1'b1, 8'd3);
    rd(BMD_ADDR_STATUS, 32'h61);
    wait_idle();
    rd(BMD_ADDR_STATUS, 32'h60);
    `CHK(exp_mw.size(), 0)
    intr <= 1'b1;
    repeat (6) @(posedge clk);
    rd(BMD_ADDR_STATUS, 32'h64);
    intr <= 1'b0;
    apb(BMD_ADDR_STATUS, 1'b1, 32'h60);
    rd(BMD_ADDR_STATUS, 32'h64);
    apb(BMD_ADDR_STATUS, 1'b1, 32'h64);
    {ce, intr} <= 2'b01;
    repeat (6) @(posedge clk);
    {ce, intr} <= 2'b10;
    rd(BMD_ADDR_STATUS, 32'h60);
    apb(BMD_ADDR_COMMAND, 1'b1, 32'h8);
    $display("test memory writes done");
    slow <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      rnd = xs(rnd);
      u_far.mem[32'h90 + k] = rnd;
      exp_dw.push_back(rnd);
    end
    desc(32'h60, 32'h240, 32'h8000_0006);
    run(32'h180, 1'b0, 8'd2);
    wait_idle();
    rd(BMD_ADDR_STATUS, 32'h60);
    `CHK(exp_dw.size(), 0)
    apb(BMD_ADDR_COMMAND, 1'b1, 32'h0);
    $display("test memory reads done");
    slow <= 1'b1;
    desc(32'h70, 32'h280, 32'h8000_0040);
    run(32'h1C0, 1'b1, 8'd16);
    repeat (60) @(posedge clk);
    rd(BMD_ADDR_STATUS, 32'h61);
    apb(BMD_ADDR_COMMAND, 1'b1, 32'h8);
    rd(BMD_ADDR_STATUS, 32'h60);
    load(8'd0);
    $display("test abort done");
    rnd = xs(rnd);
    drv_base <= rnd;
    err_addr <= 32'h380;
    desc(32'h78, 32'h380, 32'h8000_0008);
    exp_mw.push_back({32'h380, rnd});
    run(32'h1E0, 1'b1, 8'd2);
    wait_idle();
    rd(BMD_ADDR_STATUS, 32'h62);
    apb(BMD_ADDR_STATUS, 1'b1, 32'h62);
    rd(BMD_ADDR_STATUS, 32'h60);
    `CHK(exp_mw.size(), 0)
    $display("test memory error done");
    complete_run();
  end
endmodule
bind bmd_channel bmd_channel_checker u_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .mem_cmd(mem_cmd), .mem_rsp(mem_rsp), .drive_dmarq(drive_dmarq),
  .drive_rdata(drive_rdata), .drive_dmack(drive_dmack), .drive_wdata(drive_wdata));
`default_nettype wire

/* test/bmd_far.sv */
// Purpose: Memory and drive model facing the disk channel DMA block.
// Assumes: Memory words are indexed by address bits 9:2.
// Notes:   Released lines toggle so a stale value never looks valid.
`timescale 1ns/1ps
`default_nettype none
module bmd_far (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     slow,
  input  wire logic [31:0]              err_addr,
  input  wire bmd_pkg::bmd_mem_cmd_type mem_cmd,
  output var  bmd_pkg::bmd_mem_rsp_type mem_rsp,
  input  wire logic                     drv_load,
  input  wire logic [7:0]               drv_words,
  input  wire logic [31:0]              drv_base,
  input  wire logic                     drive_dmack,
  output var  logic                     drive_dmarq,
  output var  logic [31:0]              drive_rdata
);
  import bmd_pkg::*;
  logic [31:0] mem [0:255];
  logic [3:0]  wait_c;
  logic [3:0]  gap_c;
  logic [7:0]  left;
  logic [7:0]  seq;
  // --------
  // Memory: the bench preloads it, so this is not an always_ff.
  // --------
  always @(posedge clk) begin
    mem_rsp.ack   <= 1'b0;
    mem_rsp.err   <= 1'b0;
    mem_rsp.rdata <= ~mem_rsp.rdata;
    wait_c        <= 4'h0;
    if (rst) begin
      mem_rsp <= '0;
    end else if (mem_cmd.req && !mem_rsp.ack) begin
      if (wait_c < (slow ? 4'h3 : 4'h0)) begin
        wait_c <= wait_c + 4'h1;
      end else begin
        mem_rsp.ack <= 1'b1;
        mem_rsp.err <= mem_cmd.addr == err_addr;
        if (mem_cmd.we) begin
          mem[mem_cmd.addr[9:2]] <= mem_cmd.wdata;
        end else begin
          mem_rsp.rdata <= mem[mem_cmd.addr[9:2]];
        end
      end
    end
  end
  // --------
  // Drive: data holds while the request stands; low gap lets it resync.
  // --------
  always_ff @(posedge clk) begin
    if (rst || drv_load) begin
      drive_dmarq <= 1'b0;
      drive_rdata <= ~drv_base;
      left        <= drv_words;
      seq         <= 8'h00;
      gap_c       <= 4'h0;
    end else if (drive_dmarq) begin
      if (drive_dmack) begin
        drive_dmarq <= 1'b0;
        left        <= left - 8'h01;
        seq         <= seq + 8'h01;
      end
    end else begin
      drive_rdata <= ~drive_rdata;
      gap_c       <= gap_c + 4'h1;
      if (left != 8'h00 && gap_c >= (slow ? 4'h9 : 4'h4)) begin
        drive_dmarq <= 1'b1;
        drive_rdata <= drv_base ^ {24'h0, seq};
        gap_c       <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire
